// file: hw/tcb_pkg.sv
// Shared constants, field layouts and helpers of the 18-bit timer control block
package tcb_pkg;

  // Register byte addresses, decoded on haddr[7:0]
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h14;
  localparam logic [7:0] ADDR_CMP_LOW = 8'h18;
  localparam logic [7:0] ADDR_CMP_MID = 8'h1c;
  localparam logic [7:0] ADDR_CMP_HIGH = 8'h20;
  localparam logic [7:0] ADDR_GATE = 8'h24;
  localparam logic [7:0] ADDR_CFG = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2c;

  // Reset values
  localparam logic [7:0] CTRL_ONE_RST = 8'h88;
  localparam logic [7:0] GATE_RST = 8'h00;
  localparam logic [4:0] CFG_RST = 5'h00;

  // Widths
  localparam int CNT_W = 18;
  localparam int MAIN_DIV_W = 23;
  localparam int SUB_DIV_W = 15;

  // Run control codes
  localparam logic [1:0] RUN_STOP = 2'h0;
  localparam logic [1:0] RUN_GO = 2'h2;

  // Source clock codes
  localparam logic [2:0] SRC_MAIN = 3'h0;
  localparam logic [2:0] SRC_SUB = 3'h1;
  localparam logic [2:0] SRC_TAP_A = 3'h2;
  localparam logic [2:0] SRC_TAP_B = 3'h3;
  localparam logic [2:0] SRC_TAP_C = 3'h4;
  localparam logic [2:0] SRC_MAIN_D128 = 3'h5;
  localparam logic [2:0] SRC_MAIN_D8 = 3'h6;
  localparam logic [2:0] SRC_EXT = 3'h7;

  // Divider tap exponents (main / sub oscillator)
  localparam int TAP_A_MAIN = 23;
  localparam int TAP_A_SUB = 15;
  localparam int TAP_B_MAIN = 13;
  localparam int TAP_B_SUB = 5;
  localparam int TAP_C_MAIN = 11;
  localparam int TAP_C_SUB = 3;
  localparam int TAP_D128 = 7;
  localparam int TAP_D8 = 3;
  localparam int GATE_MAIN_BASE = 12;
  localparam int GATE_SUB_BASE = 4;
  localparam logic [1:0] GATE_SEL_RSVD = 2'h3;

  // Gate phase spans sixteen base periods minus the programmed count
  localparam int PHASE_SPAN = 16;
  localparam logic [3:0] PHASE_LAST = 4'(PHASE_SPAN - 1);

  typedef enum logic [1:0] {MODE_TIMER, MODE_EVENT, MODE_PULSE, MODE_RSVD} tcb_mode_e;
  typedef enum logic [1:0] {PWR_NORMAL, PWR_IDLE, PWR_SLOW, PWR_SLEEP} tcb_power_e;

  typedef struct packed {
    logic clear_control_bit;
    logic [1:0] run_control_field;
    logic [2:0] source_clock_select;
    tcb_mode_e mode_select_field;
  } tcb_ctrl_one_s;

  typedef struct packed {
    logic [3:0] high_phase_count;
    logic [3:0] low_phase_count;
  } tcb_gate_s;

  typedef struct packed {
    logic gate_event;
    logic gate_enable;
    logic slow_tap_select;
    logic [1:0] gate_clock_select;
  } tcb_cfg_s;

  // True when the low n bits of a divider are all ones
  function automatic logic tap_hit(logic [MAIN_DIV_W-1:0] v, int n);
    logic [MAIN_DIV_W-1:0] m;
    m = ~({MAIN_DIV_W{1'b1}} << n);
    return (v & m) == m;
  endfunction

endpackage

// file: hw/tcb_gate_gen.sv
// Window gate pulse generator with programmable high and low phases
`timescale 1ns/100ps
`default_nettype none
module tcb_gate_gen (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic enable,
  input wire logic base_tick,
  input wire tcb_pkg::tcb_gate_s phases,
  // Gate
  output logic gate_level
);

  typedef struct packed {
    logic active;
    logic level;
    logic [3:0] cnt;
  } tcb_gate_state_s;

  tcb_gate_state_s st_r;
  tcb_gate_state_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!enable) begin
      st_nxt = '0;
    end else if (!st_r.active) begin
      st_nxt.active = 1'b1;
      st_nxt.level = 1'b1;
      st_nxt.cnt = phases.high_phase_count;
    end else if (base_tick) begin
      if (st_r.cnt == tcb_pkg::PHASE_LAST) begin
        st_nxt.level = ~st_r.level;
        // High phase lasts sixteen minus its count
        if (!st_r.level) st_nxt.cnt = phases.high_phase_count; // R15
        // Low phase lasts sixteen minus its count
        else st_nxt.cnt = phases.low_phase_count; // R16
      end else begin
        st_nxt.cnt = 4'(st_r.cnt + 4'h1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign gate_level = st_r.level;

endmodule
`default_nettype wire

// file: hw/tcb_timer.sv
// 18-bit timer/counter control block with AHB-Lite register slave
// Operation
// R01 - Run code 00 stops and clears the counter, 10 runs, odd codes reserved.
// R02 - Software changes mode, source and edges only while stopped.
// R03 - Low or middle compare byte write inhibits matching until high byte write.
// R04 - Compare register reads return the live count, not the compare value.
// R05 - Software should read the count only while stopped.
// R06 - Software loads a compare value of at least one.
// R07 - Timer and pulse width modes use an internal source clock.
// R08 - Event counter mode uses the external clock input.
// R09 - Software never read-modify-writes the compare register.
// R10 - Main divided by 128 and 8 are unavailable in slow and sleep modes.
// R11 - Undivided main clock only in allowed mode and power combinations; the code ticks SRC_MAIN in every mode and power mode.
// R12 - Compare high byte bits 7 to 2 read zero and ignore writes.
// R13 - Source select decodes main, sub, divider taps, main/128 and main/8.
// R14 - Writing zero to the clear bit clears counter and overflow flag; the code keeps an overflow set in the same cycle.
// R15 - Gate high phase lasts sixteen minus high count base periods.
// R16 - Gate low phase lasts sixteen minus low count base periods.
// R17 - Compare value is 18 bits, reached as low, middle, high bytes.
// R18 - An 8-bit register holds the high and low gate phase counts.
// R19 - Timer mode match raises the match pulse, clears and keeps counting.
// R20 - Two-bit mode field: timer, event, pulse width, one reserved code.
`timescale 1ns/100ps
`default_nettype none
module tcb_timer (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // System
  input wire tcb_pkg::tcb_power_e power_mode,
  input wire logic sub_osc_tick,
  input wire logic ext_clock_in,
  // Events
  output logic match_interrupt,
  output logic overflow_flag,
  output logic window_gate
);

  typedef struct packed {
    tcb_pkg::tcb_ctrl_one_s ctrl;
    tcb_pkg::tcb_gate_s gate;
    tcb_pkg::tcb_cfg_s cfg;
    logic [17:0] compare;
    logic inhibit;
    logic [17:0] count;
    logic ovf;
    logic match;
    logic [22:0] main_div;
    logic [14:0] sub_div;
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic a_valid;
    logic a_write;
    logic [7:0] a_addr;
    logic rd_wait;
    logic [31:0] rdata;
  } tcb_state_s;

  tcb_state_s st_r;
  tcb_state_s st_nxt;
  logic gate_level;
  logic gate_tick;
  logic gate_run;

  // Pick a divider tap of the main or the sub oscillator
  function automatic logic tap_pick(logic use_sub, logic sub_tick, logic [22:0] main_div,
                                    logic [14:0] sub_div, int main_exp, int sub_exp);
    if (use_sub) return sub_tick & tcb_pkg::tap_hit({8'h00, sub_div}, sub_exp);
    return tcb_pkg::tap_hit(main_div, main_exp);
  endfunction

  logic slow;
  logic use_sub;
  logic src_tick;
  logic ext_fall;
  logic cnt_en;
  logic take;
  logic clr_req;
  logic armed;
  logic [17:0] cnt_inc;
  logic [31:0] rd_val;

  always_comb begin
    slow = (power_mode == tcb_pkg::PWR_SLOW) || (power_mode == tcb_pkg::PWR_SLEEP);
    use_sub = slow | st_r.cfg.slow_tap_select;
    ext_fall = st_r.ext_prev & ~st_r.ext_s2;
    unique case (st_r.ctrl.source_clock_select) // R13
      tcb_pkg::SRC_MAIN: src_tick = 1'b1;
      tcb_pkg::SRC_SUB: src_tick = sub_osc_tick & ~slow;
      tcb_pkg::SRC_TAP_A: src_tick = tap_pick(use_sub, sub_osc_tick, st_r.main_div,
                                              st_r.sub_div, tcb_pkg::TAP_A_MAIN,
                                              tcb_pkg::TAP_A_SUB);
      tcb_pkg::SRC_TAP_B: src_tick = tap_pick(use_sub, sub_osc_tick, st_r.main_div,
                                              st_r.sub_div, tcb_pkg::TAP_B_MAIN,
                                              tcb_pkg::TAP_B_SUB);
      tcb_pkg::SRC_TAP_C: src_tick = tap_pick(use_sub, sub_osc_tick, st_r.main_div,
                                              st_r.sub_div, tcb_pkg::TAP_C_MAIN,
                                              tcb_pkg::TAP_C_SUB);
      // Main oscillator fractions give no tick in slow and sleep modes
      tcb_pkg::SRC_MAIN_D128:
        src_tick = ~slow & tcb_pkg::tap_hit(st_r.main_div, tcb_pkg::TAP_D128); // R10
      tcb_pkg::SRC_MAIN_D8:
        src_tick = ~slow & tcb_pkg::tap_hit(st_r.main_div, tcb_pkg::TAP_D8); // R10
      tcb_pkg::SRC_EXT: src_tick = ext_fall;
    endcase
    if (st_r.cfg.gate_clock_select == tcb_pkg::GATE_SEL_RSVD) begin
      gate_tick = 1'b0;
    end else begin
      gate_tick = tap_pick(use_sub, sub_osc_tick, st_r.main_div, st_r.sub_div,
                           tcb_pkg::GATE_MAIN_BASE + int'(st_r.cfg.gate_clock_select),
                           tcb_pkg::GATE_SUB_BASE + int'(st_r.cfg.gate_clock_select));
    end
    gate_run = st_r.cfg.gate_enable && (st_r.ctrl.run_control_field == tcb_pkg::RUN_GO);
  end

  tcb_gate_gen u_gate (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(gate_run),
    .base_tick(gate_tick),
    .phases(st_r.gate),
    .gate_level(gate_level)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.match = 1'b0;
    clr_req = 1'b0;
    armed = ~st_r.inhibit;
    take = hsel & htrans[1] & hready;
    cnt_inc = 18'(st_r.count + 18'h00001);
    rd_val = 32'h00000000;

    // Dividers and external input synchroniser
    st_nxt.main_div = 23'(st_r.main_div + 23'h000001);
    if (sub_osc_tick) st_nxt.sub_div = 15'(st_r.sub_div + 15'h0001);
    st_nxt.ext_s1 = ext_clock_in;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.ext_prev = st_r.ext_s2;

    // Read data: compare bytes show the live count
    unique case (st_r.a_addr)
      tcb_pkg::ADDR_CTRL_ONE: rd_val = {24'h000000, st_r.ctrl};
      tcb_pkg::ADDR_CMP_LOW: rd_val = {24'h000000, st_r.count[7:0]}; // R04
      tcb_pkg::ADDR_CMP_MID: rd_val = {24'h000000, st_r.count[15:8]}; // R04
      tcb_pkg::ADDR_CMP_HIGH: rd_val = {30'h00000000, st_r.count[17:16]}; // R04 R12
      tcb_pkg::ADDR_GATE: rd_val = {24'h000000, st_r.gate}; // R18
      tcb_pkg::ADDR_CFG: rd_val = {27'h0000000, st_r.cfg};
      tcb_pkg::ADDR_STATUS: rd_val = {28'h0000000,
                                      st_r.ctrl.run_control_field == tcb_pkg::RUN_GO,
                                      armed, gate_level, st_r.ovf};
      default: rd_val = 32'h00000000;
    endcase

    // Bus: reads take one wait state, writes none
    if (st_r.rd_wait) begin
      st_nxt.rdata = rd_val;
      st_nxt.rd_wait = 1'b0;
    end else begin
      if (st_r.a_valid && st_r.a_write) begin
        unique case (st_r.a_addr)
          tcb_pkg::ADDR_CTRL_ONE: begin
            st_nxt.ctrl = tcb_pkg::tcb_ctrl_one_s'(hwdata[7:0]);
            // The clear bit acts once and reads back as one
            st_nxt.ctrl.clear_control_bit = 1'b1;
            clr_req = ~hwdata[7]; // R14
          end
          tcb_pkg::ADDR_CMP_LOW: begin
            st_nxt.compare[7:0] = hwdata[7:0]; // R17
            st_nxt.inhibit = 1'b1; // R03
          end
          tcb_pkg::ADDR_CMP_MID: begin
            st_nxt.compare[15:8] = hwdata[7:0]; // R17
            st_nxt.inhibit = 1'b1; // R03
          end
          tcb_pkg::ADDR_CMP_HIGH: begin
            st_nxt.compare[17:16] = hwdata[1:0]; // R12 R17
            st_nxt.inhibit = 1'b0; // R03
          end
          tcb_pkg::ADDR_GATE: st_nxt.gate = tcb_pkg::tcb_gate_s'(hwdata[7:0]); // R18
          tcb_pkg::ADDR_CFG: st_nxt.cfg = tcb_pkg::tcb_cfg_s'(hwdata[4:0]);
          default: ;
        endcase
      end
      st_nxt.a_valid = take;
      st_nxt.a_write = hwrite;
      st_nxt.a_addr = haddr[7:0];
      st_nxt.rd_wait = take & ~hwrite;
    end

    // Counting condition per mode
    unique case (st_r.ctrl.mode_select_field) // R20
      tcb_pkg::MODE_TIMER: cnt_en = src_tick; // R07
      tcb_pkg::MODE_EVENT: cnt_en = src_tick & (~st_r.cfg.gate_event | gate_level); // R08
      tcb_pkg::MODE_PULSE: cnt_en = src_tick & st_r.ext_s2;
      tcb_pkg::MODE_RSVD: cnt_en = 1'b0;
    endcase
    if (st_r.ctrl.run_control_field != tcb_pkg::RUN_GO) cnt_en = 1'b0; // R01

    if (st_r.ctrl.run_control_field == tcb_pkg::RUN_STOP) begin
      st_nxt.count = 18'h00000; // R01
    end else if (cnt_en) begin
      // Match on reaching the compare value, so the period equals it
      if (armed && (st_r.ctrl.mode_select_field != tcb_pkg::MODE_PULSE)
          && (cnt_inc == st_r.compare)) begin // R06
        st_nxt.count = 18'h00000; // R19
        st_nxt.match = 1'b1; // R19
      end else begin
        st_nxt.count = cnt_inc;
        if (&st_r.count) st_nxt.ovf = 1'b1;
      end
    end

    // Clear request: overflow set in the same cycle survives
    if (clr_req) begin
      st_nxt.count = 18'h00000; // R14
      if (!(cnt_en && (&st_r.count) && !st_nxt.match)) st_nxt.ovf = 1'b0; // R14
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.ctrl <= tcb_pkg::tcb_ctrl_one_s'(tcb_pkg::CTRL_ONE_RST);
      st_r.gate <= tcb_pkg::tcb_gate_s'(tcb_pkg::GATE_RST);
      st_r.cfg <= tcb_pkg::tcb_cfg_s'(tcb_pkg::CFG_RST);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata = st_r.rdata;
  assign hreadyout = ~st_r.rd_wait;
  assign hresp = 1'b0;
  assign match_interrupt = st_r.match;
  assign overflow_flag = st_r.ovf;
  assign window_gate = gate_level;

endmodule
`default_nettype wire

// file: verif/tcb_timer_assertions.sv
// Concurrent checks on the port behaviour of the timer control block
`timescale 1ns/100ps
`default_nettype none
module tcb_timer_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  // Events
  input wire logic match_interrupt,
  input wire logic overflow_flag,
  input wire logic window_gate
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic wr_ctrl_r;
  logic [1:0] run_r;
  assign take = hsel && htrans[1] && hready;
  // Mirror of the run field, updated as a control write completes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctrl_r <= 1'b0;
      run_r <= 2'h0;
    end else begin
      wr_ctrl_r <= take && hwrite && haddr[7:0] == tcb_pkg::ADDR_CTRL_ONE;
      if (wr_ctrl_r) run_r <= hwdata[6:5];
    end
  end
  sequence s_rd(a); take && !hwrite && haddr[7:0] == a; endsequence
  sequence s_wait_one; !hreadyout ##1 hreadyout; endsequence
  sequence s_wr_ctrl; take && hwrite && haddr[7:0] == tcb_pkg::ADDR_CTRL_ONE; endsequence
  property p_read_wait; take && !hwrite |=> s_wait_one; endproperty
  property p_write_nowait; take && hwrite |=> hreadyout; endproperty
  property p_high_byte; s_rd(tcb_pkg::ADDR_CMP_HIGH) |=> ##1 hrdata[31:2] == 30'h0; endproperty
  property p_byte_wide;
    take && !hwrite && haddr[7:0] inside {8'h18, 8'h1c, 8'h24} |=> ##1 hrdata[31:8] == 24'h0;
  endproperty
  property p_clear; s_wr_ctrl ##1 !hwdata[7] |=> !overflow_flag; endproperty
  property p_stop_zero;
    s_rd(tcb_pkg::ADDR_CMP_LOW) ##0 (run_r == 2'h0 && !wr_ctrl_r) |=> ##1 hrdata[7:0] == 8'h0;
  endproperty
  property p_stop_gate; (run_r == 2'h0) [*3] |-> !window_gate; endproperty
  property p_stop_match; (run_r == 2'h0) [*3] |-> !match_interrupt; endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
  a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
  a_high_byte: assert property (p_high_byte) else $error("high byte upper bits set");
  a_byte_wide: assert property (p_byte_wide) else $error("byte register too wide");
  a_clear: assert property (p_clear) else $error("overflow not cleared");
  a_stop_zero: assert property (p_stop_zero) else $error("stopped count not zero");
  a_stop_gate: assert property (p_stop_gate) else $error("gate high while stopped");
  a_stop_match: assert property (p_stop_match) else $error("match while stopped");
endmodule
bind tcb_timer tcb_timer_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .match_interrupt(match_interrupt),
  .overflow_flag(overflow_flag), .window_gate(window_gate));
`default_nettype wire

// file: verif/tcb_timer_tb.sv
// Self-checking register-level testbench of the timer control block
`timescale 1ns/100ps
`default_nettype none
module tcb_timer_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sub_osc_tick, ext_clock_in;
  logic match_interrupt, overflow_flag, window_gate;
  logic [31:0] haddr, hwdata, hrdata, d, d2;
  logic [1:0] htrans;
  tcb_pkg::tcb_power_e pm;
  int mismatches, tests_run, cyc, p, m0, match_cnt;
  logic [2:0] srcs [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
  int exps [6] = '{5, 20, 160, 640, 40, 30};
  tcb_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .power_mode(pm),
    .sub_osc_tick(sub_osc_tick), .ext_clock_in(ext_clock_in),
    .match_interrupt(match_interrupt), .overflow_flag(overflow_flag),
    .window_gate(window_gate));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Sub oscillator tick every 4 cycles, external input toggles every 3
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    sub_osc_tick <= (cyc % 4 == 3);
    if (cyc % 3 == 2) ext_clock_in <= ~ext_clock_in;
    if (cyc == 60000) begin
      mismatches++;
      print_verdict();
    end
  end
  always @(negedge hclk) if (match_interrupt === 1'b1) match_cnt++;
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single AHB-Lite transfer; ready is sampled at each rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
  endtask
  function automatic logic [31:0] ctl(logic c, logic [1:0] r, logic [2:0] s, logic [1:0] m);
    return {24'h0, c, r, s, m};
  endfunction
  // Cycles from an edge of a signal to a later edge (g selects the gate)
  task automatic span(input bit g, input logic a, input logic b, output int n);
    logic pv, c;
    c = g ? window_gate : match_interrupt;
    do begin pv = c; @(negedge hclk); c = g ? window_gate : match_interrupt; end
      while (!(pv !== a && c === a));
    n = 0;
    do begin pv = c; @(negedge hclk); c = g ? window_gate : match_interrupt; n++; end
      while (!(pv !== b && c === b));
    @(posedge hclk);
  endtask
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, sub_osc_tick, ext_clock_in} = '0;
    {cyc, mismatches, tests_run, match_cnt} = '0;
    pm = tcb_pkg::PWR_NORMAL;
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, tcb_pkg::ADDR_CTRL_ONE, 0, d); check(d, 32'h88);
    bus(1'b0, tcb_pkg::ADDR_GATE, 0, d); check(d, 32'h0);
    check({31'h0, hresp}, 32'h0);
    wr(tcb_pkg::ADDR_CMP_LOW, 32'h5);
    wr(tcb_pkg::ADDR_CMP_MID, 32'h0);
    wr(tcb_pkg::ADDR_CMP_HIGH, 32'hfc);
    bus(1'b0, tcb_pkg::ADDR_CMP_LOW, 0, d); check(d, 32'h0);
    bus(1'b0, tcb_pkg::ADDR_CMP_HIGH, 0, d); check(d, 32'h0);
    wr(tcb_pkg::ADDR_GATE, 32'hef);
    bus(1'b0, tcb_pkg::ADDR_GATE, 0, d); check(d, 32'hef);
    wr(tcb_pkg::ADDR_CFG, 32'h0c);
    for (int i = 0; i < 6; i++) begin
      wr(tcb_pkg::ADDR_CTRL_ONE, ctl(1'b1, 2'h0, srcs[i], (i == 5) ? 2'h1 : 2'h0));
      wr(tcb_pkg::ADDR_CTRL_ONE, ctl(1'b1, 2'h2, srcs[i], (i == 5) ? 2'h1 : 2'h0));
      span(1'b0, 1'b1, 1'b1, p); check(32'(p), 32'(exps[i]));
    end
    wr(tcb_pkg::ADDR_CTRL_ONE, ctl(1'b1, 2'h0, 3'h0, 2'h0));
    wr(tcb_pkg::ADDR_CTRL_ONE, ctl(1'b1, 2'h2, 3'h0, 2'h0));
    span(1'b0, 1'b1, 1'b1, p); check(32'(p), 32'h5);
    span(1'b1, 1'b0, 1'b1, p); check(32'(p), 32'h40);
    span(1'b1, 1'b1, 1'b0, p); check(32'(p), 32'h80);
    wr(tcb_pkg::ADDR_CMP_LOW, 32'h40);
    @(posedge hclk);
    m0 = match_cnt;
    repeat (20) @(posedge hclk);
    check(32'(match_cnt - m0), 32'h0);
    wr(tcb_pkg::ADDR_CMP_HIGH, 32'h0);
    span(1'b0, 1'b1, 1'b1, p); check(32'(p), 32'h40);
    wr(tcb_pkg::ADDR_CTRL_ONE, ctl(1'b1, 2'h1, 3'h0, 2'h0));
    bus(1'b0, tcb_pkg::ADDR_CMP_LOW, 0, d);
    bus(1'b0, tcb_pkg::ADDR_CMP_LOW, 0, d2); check(d2, d);
    wr(tcb_pkg::ADDR_CTRL_ONE, ctl(1'b0, 2'h1, 3'h0, 2'h0));
    bus(1'b0, tcb_pkg::ADDR_CMP_LOW, 0, d); check(d, 32'h0);
    check({31'h0, overflow_flag}, 32'h0);
    // Main divided by 8 gives no tick in slow mode
    pm <= tcb_pkg::PWR_SLOW;
    wr(tcb_pkg::ADDR_CTRL_ONE, ctl(1'b1, 2'h0, 3'h6, 2'h0));
    wr(tcb_pkg::ADDR_CTRL_ONE, ctl(1'b1, 2'h2, 3'h6, 2'h0));
    m0 = match_cnt;
    repeat (600) @(posedge hclk);
    check(32'(match_cnt - m0), 32'h0);
    wr(tcb_pkg::ADDR_CTRL_ONE, ctl(1'b1, 2'h0, 3'h6, 2'h0));
    pm <= tcb_pkg::PWR_NORMAL;
    wr(tcb_pkg::ADDR_CTRL_ONE, ctl(1'b1, 2'h2, 3'h0, 2'h0));
    repeat (3) @(posedge hclk);
    wr(tcb_pkg::ADDR_CTRL_ONE, ctl(1'b1, 2'h0, 3'h0, 2'h0));
    bus(1'b0, tcb_pkg::ADDR_CMP_LOW, 0, d); check(d, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
